// file: pkg/vsx_defs.vh
// Purpose: constants for the vector subtract / widen / xor slice
// Assumes: 32-bit instruction word, 64-bit operands
// Notes: definitions only
`ifndef VSX_DEFS_VH
`define VSX_DEFS_VH
`define VSX_PRIMARY_OPC 6'h0a
`define VSX_PRI_HI 31
`define VSX_PRI_LO 26
`define VSX_RD_HI 25
`define VSX_RD_LO 21
`define VSX_RA_HI 20
`define VSX_RA_LO 16
`define VSX_RB_HI 15
`define VSX_RB_LO 11
`define VSX_SEC_HI 7
`define VSX_SEC_LO 0
`define VSX_OP_SUB_B 8'h71
`define VSX_OP_SUB_H 8'h72
`define VSX_OP_SUBS_B 8'h73
`define VSX_OP_SUBS_H 8'h74
`define VSX_OP_SUBU_B 8'h75
`define VSX_OP_SUBU_H 8'h76
`define VSX_OP_SUBUS_B 8'h77
`define VSX_OP_SUBUS_H 8'h78
`define VSX_OP_WIDEN_N 8'h79
`define VSX_OP_WIDEN_B 8'h7a
`define VSX_OP_XOR 8'h7b
`endif

// file: design/vsx_alu.v
// Purpose: vector subtract, sign-widen and xor slice of a 64-bit core
// Assumes: operands read from the register file in the issue cycle
// Notes: one-cycle latency; result and write enable registered
//   result and destination hold until the next accepted operation
//   widen forms read only the first source; the second is ignored
//   saturating lanes are clamped one at a time; lanes never interact
// Behaviour
// - opcode 0x71: eight byte lanes, first minus second, wrapping.
// - byte subtract decoded from secondary opcode 0x71.
// - opcode 0x72: four half-word lanes subtracted with wraparound.
// - opcode 0x73: signed byte differences clamped to -128..127.
// - opcode 0x74: signed half differences clamped to -32768..32767.
// - opcode 0x75: unsigned byte lanes subtracted modulo 256.
// - opcode 0x76: unsigned half lanes subtracted with wraparound.
// - opcode 0x77: unsigned byte subtract, negative results become zero.
// - opcode 0x78: unsigned half subtract, negative results become zero.
// - opcode 0x79: low eight nibbles sign-extended into byte lanes.
// - opcode 0x7a: low four bytes sign-extended into half lanes.
// - opcode 0x7b: full 64-bit exclusive-or of both sources.
// - saturating forms clamp to type min or max, never wrap.
`timescale 1ns/1ps
`include "vsx_defs.vh"

module vsx_alu (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // issue side
  input wire issue_valid,
  input wire [31:0] instr,
  input wire [63:0] first_source_operand,
  input wire [63:0] second_source_operand,
  // result side
  output reg result_valid_r,
  output reg [4:0] result_dest_r,
  output reg [63:0] result_data_r,
  output reg unit_hit_r
);

  // lane subtract modes; the wrap form serves the plain and the unsigned
  // opcodes alike, since modulo arithmetic does not care about signedness
  localparam [1:0] MODE_WRAP = 2'h0;
  localparam [1:0] MODE_SSAT = 2'h1;
  localparam [1:0] MODE_USAT = 2'h2;

  // signed byte clamp: a 9-bit difference whose top two bits disagree has
  // left the -128..127 range; the top bit tells which end to pin to
  function [7:0] clamp_signed_byte;
    input [8:0] d;
    begin
      if (d[8] != d[7])
        clamp_signed_byte = d[8] ? 8'h80 : 8'h7f;
      else
        clamp_signed_byte = d[7:0];
    end
  endfunction

  // signed half clamp, same test one lane size up
  function [15:0] clamp_signed_half;
    input [16:0] d;
    begin
      if (d[16] != d[15])
        clamp_signed_half = d[16] ? 16'h8000 : 16'h7fff;
      else
        clamp_signed_half = d[15:0];
    end
  endfunction

  // unsigned byte clamp: a borrow out means the true difference is negative,
  // and the floor of the unsigned range is zero; no lane can pass the top
  function [7:0] clamp_unsigned_byte;
    input [8:0] d;
    begin
      if (d[8])
        clamp_unsigned_byte = 8'h00;
      else
        clamp_unsigned_byte = d[7:0];
    end
  endfunction

  // unsigned half clamp, borrow out pins the lane to zero
  function [15:0] clamp_unsigned_half;
    input [16:0] d;
    begin
      if (d[16])
        clamp_unsigned_half = 16'h0000;
      else
        clamp_unsigned_half = d[15:0];
    end
  endfunction

  // one byte lane: both differences are formed one bit wider so that the
  // clamps can see overflow and borrow; the wrap form just drops that bit
  function [7:0] byte_diff;
    input [7:0] a;
    input [7:0] b;
    input [1:0] mode;
    reg [8:0] ds;
    reg [8:0] du;
    begin
      ds = {a[7], a} - {b[7], b};
      du = {1'b0, a} - {1'b0, b};
      case (mode)
        MODE_SSAT: byte_diff = clamp_signed_byte(ds);
        MODE_USAT: byte_diff = clamp_unsigned_byte(du);
        default: byte_diff = du[7:0];
      endcase
    end
  endfunction

  // one half-word lane, same three modes on 17-bit differences
  // the unsigned clamp never has to look past the borrow bit
  function [15:0] half_diff;
    input [15:0] a;
    input [15:0] b;
    input [1:0] mode;
    reg [16:0] ds;
    reg [16:0] du;
    begin
      ds = {a[15], a} - {b[15], b};
      du = {1'b0, a} - {1'b0, b};
      case (mode)
        MODE_SSAT: half_diff = clamp_signed_half(ds);
        MODE_USAT: half_diff = clamp_unsigned_half(du);
        default: half_diff = du[15:0];
      endcase
    end
  endfunction

  // instruction fields
  wire [5:0] pri_opc = instr[`VSX_PRI_HI:`VSX_PRI_LO];
  wire [7:0] sec_opc = instr[`VSX_SEC_HI:`VSX_SEC_LO];
  wire [4:0] dest_fld = instr[`VSX_RD_HI:`VSX_RD_LO];
  // reserved bits 10..8 and the source fields are not checked here: operands
  // arrive already read, and no illegal-instruction path exists for this unit
  // ownership needs the primary opcode only here; the secondary opcode is
  // judged by the datapath case, whose default branch clears the hit
  wire is_vec = (pri_opc == `VSX_PRIMARY_OPC);

  // next result and hit flag of the lane datapath
  reg [63:0] res_nxt;
  reg hit_nxt;
  // lane loop index, used by the datapath process alone
  integer i;

  // lane datapath selected by secondary opcode; every path writes both
  // outputs, and a refused opcode leaves a zero result with the hit cleared
  always @* begin
    res_nxt = 64'h0;
    hit_nxt = 1'b1;
    case (sec_opc)
      `VSX_OP_SUB_B, `VSX_OP_SUBU_B: begin
        for (i = 0; i < 8; i = i + 1)
          res_nxt[i*8 +: 8] = byte_diff(first_source_operand[i*8 +: 8],
            second_source_operand[i*8 +: 8], MODE_WRAP);
      end
      `VSX_OP_SUB_H, `VSX_OP_SUBU_H: begin
        for (i = 0; i < 4; i = i + 1)
          res_nxt[i*16 +: 16] = half_diff(first_source_operand[i*16 +: 16],
            second_source_operand[i*16 +: 16], MODE_WRAP);
      end
      `VSX_OP_SUBS_B: begin
        for (i = 0; i < 8; i = i + 1)
          res_nxt[i*8 +: 8] = byte_diff(first_source_operand[i*8 +: 8],
            second_source_operand[i*8 +: 8], MODE_SSAT);
      end
      `VSX_OP_SUBS_H: begin
        for (i = 0; i < 4; i = i + 1)
          res_nxt[i*16 +: 16] = half_diff(first_source_operand[i*16 +: 16],
            second_source_operand[i*16 +: 16], MODE_SSAT);
      end
      `VSX_OP_SUBUS_B: begin
        for (i = 0; i < 8; i = i + 1)
          res_nxt[i*8 +: 8] = byte_diff(first_source_operand[i*8 +: 8],
            second_source_operand[i*8 +: 8], MODE_USAT);
      end
      `VSX_OP_SUBUS_H: begin
        for (i = 0; i < 4; i = i + 1)
          res_nxt[i*16 +: 16] = half_diff(first_source_operand[i*16 +: 16],
            second_source_operand[i*16 +: 16], MODE_USAT);
      end
      `VSX_OP_WIDEN_N: begin
        for (i = 0; i < 8; i = i + 1)
          res_nxt[i*8 +: 8] = {{4{first_source_operand[i*4+3]}},
            first_source_operand[i*4 +: 4]};
      end
      `VSX_OP_WIDEN_B: begin
        for (i = 0; i < 4; i = i + 1)
          res_nxt[i*16 +: 16] = {{8{first_source_operand[i*8+7]}},
            first_source_operand[i*8 +: 8]};
      end
      `VSX_OP_XOR: begin
        res_nxt = first_source_operand ^ second_source_operand;
      end
      default: begin
        hit_nxt = 1'b0;
      end
    endcase
  end

  // result stage; no exception output exists, by design
  // unit_hit_r follows the decode alone, so the core can tell an idle slot
  // that holds one of these opcodes from a foreign instruction
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      result_valid_r <= 1'b0;
      result_dest_r <= 5'h00;
      result_data_r <= 64'h0;
      unit_hit_r <= 1'b0;
    end else begin
      result_valid_r <= issue_valid & is_vec & hit_nxt;
      unit_hit_r <= is_vec & hit_nxt;
      // data and destination move only on an accepted op, so idle and
      // refused cycles cannot disturb the last written result
      if (issue_valid & is_vec & hit_nxt) begin
        result_dest_r <= dest_fld;
        result_data_r <= res_nxt;
      end
    end
  end

endmodule // vsx_alu

// file: dv/vsx_alu_asserts.sv
// Purpose: port checks for vsx_alu
// Assumes: one clock, sync low reset
// Notes: bound to every vsx_alu
`timescale 1ns/1ps
module vsx_alu_asserts (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // issue side
  input wire issue_valid,
  input wire [31:0] instr,
  input wire [63:0] first_source_operand,
  input wire [63:0] second_source_operand,
  // result side
  input wire result_valid_r,
  input wire [4:0] result_dest_r,
  input wire [63:0] result_data_r,
  input wire unit_hit_r
);
  // short aliases keep lines narrow
  wire [63:0] a = first_source_operand;
  wire [63:0] b = second_source_operand;
  wire [7:0] op = instr[7:0];
  wire hit = issue_valid && instr[31:26] == 6'h0a && op >= 8'h71 && op <= 8'h7b;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take(logic [7:0] c);
    hit && op == c;
  endsequence
  a_valid_pulse: assert property (hit |=> result_valid_r)
    else $error("no valid");
  a_no_spurious: assert property (!hit |=> !result_valid_r)
    else $error("stray valid");
  a_dest_capture: assert property (hit |=> result_dest_r == $past(instr[25:21]))
    else $error("bad dest");
  a_data_holds: assert property (!hit |=> $stable(result_data_r))
    else $error("data moved");
  a_byte_wrap: assert property (s_take(8'h71) |=>
    result_data_r[15:8] == $past(a[15:8]) - $past(b[15:8])) else $error("bad byte sub");
  a_ubyte_floor: assert property (s_take(8'h77) ##0 a[15:8] < b[15:8] |=>
    result_data_r[15:8] == 8'h00) else $error("no floor");
  a_nibble_widen: assert property (s_take(8'h79) |=>
    result_data_r[63:56] == {{4{$past(a[31])}}, $past(a[31:28])}) else $error("bad widen");
  a_xor_full: assert property (s_take(8'h7b) |=> result_data_r == $past(a ^ b))
    else $error("bad xor");
endmodule // vsx_alu_asserts
bind vsx_alu vsx_alu_asserts u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .issue_valid(issue_valid),
  .instr(instr),
  .first_source_operand(first_source_operand),
  .second_source_operand(second_source_operand),
  .result_valid_r(result_valid_r),
  .result_dest_r(result_dest_r),
  .result_data_r(result_data_r),
  .unit_hit_r(unit_hit_r)
);

// file: dv/vsx_pipe.sv
// Purpose: issue side of the core pipeline
// Assumes: dest field = low opcode bits
// Notes: released operands show their inverse
`timescale 1ns/1ps
module vsx_pipe (
  // clock
  input wire sys_clk,
  // issue side
  output logic issue_valid = 1'b0,
  output logic [31:0] instr = 32'h0,
  output logic [63:0] first_source_operand = 64'h0,
  output logic [63:0] second_source_operand = 64'h0
);
  // vector primary opcode, dest field taken from the low opcode bits
  task issue(input logic [7:0] op, input logic [63:0] a, input logic [63:0] b);
    issue_word({6'h0a, op[4:0], 13'h0, op}, a, b);
  endtask
  // hold one request across its edge, then drop it
  task issue_word(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    @(posedge sys_clk);
    #1;
    issue_valid = 1'b1;
    instr = w;
    first_source_operand = a;
    second_source_operand = b;
    @(posedge sys_clk);
    #1;
    issue_valid = 1'b0;
    first_source_operand = ~a; // stale data must not look valid
    second_source_operand = ~b;
  endtask
endmodule // vsx_pipe

// file: dv/vsx_alu_tb_top.sv
// Purpose: directed bench for vsx_alu
// Assumes: one operand pair hits lane limits
// Notes: results worked out by hand
`timescale 1ns/1ps
module vsx_alu_tb_top;
  logic sys_clk;
  logic rst_n = 1'b0;
  wire issue_valid, result_valid_r, unit_hit_r;
  wire [31:0] instr;
  wire [4:0] result_dest_r;
  wire [63:0] first_source_operand, second_source_operand, result_data_r;
  wire [70:0] got = {result_valid_r, unit_hit_r, result_dest_r, result_data_r};
  int fail_count = 0;
  int checks = 0;
  // one operand pair reaches every lane limit
  localparam logic [63:0] opa = 64'h807f0010ff014005;
  localparam logic [63:0] opb = 64'h01ff01200102c003;
  vsx_pipe u_pipe (
    .sys_clk(sys_clk),
    .issue_valid(issue_valid),
    .instr(instr),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand)
  );
  vsx_alu u_alu (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .issue_valid(issue_valid),
    .instr(instr),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .result_valid_r(result_valid_r),
    .result_dest_r(result_dest_r),
    .result_data_r(result_data_r),
    .unit_hit_r(unit_hit_r)
  );
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // refused ops leave the last xor result in place
  task judge(input logic [4:0] d, input logic v, input logic [63:0] e);
    logic [70:0] x;
    x = {v, v, v ? d : 5'h1b, e};
    checks++;
    if (got !== x) begin
      fail_count++;
      $display("wrong value result exp %h got %h", x, got);
    end
  endtask
  task run(input logic [7:0] op, input logic v, input logic [63:0] e);
    u_pipe.issue(op, opa, opb);
    judge(op[4:0], v, e);
  endtask
  task run_word(input logic [31:0] w, input logic v, input logic [63:0] e);
    u_pipe.issue_word(w, opa, opb);
    judge(w[25:21], v, e);
  endtask
  // all outputs low while reset is held
  task t_reset;
    checks++;
    if (got !== 71'h0) begin
      fail_count++;
      $display("wrong value reset exp %h got %h", 71'h0, got);
    end
    $display("test reset done");
  endtask
  task t_wrap;
    run(8'h71, 1, 64'h7f80fff0feff8002);
    run(8'h75, 1, 64'h7f80fff0feff8002);
    run(8'h72, 1, 64'h7e80fef0fdff8002);
    run(8'h76, 1, 64'h7e80fef0fdff8002);
    $display("test wrap done");
  endtask
  task t_sat;
    run(8'h73, 1, 64'h807ffff0feff7f02);
    run(8'h74, 1, 64'h8000fef0fdff7fff);
    run(8'h77, 1, 64'h7f000000fe000002);
    run(8'h78, 1, 64'h7e800000fdff0000);
    $display("test sat done");
  endtask
  task t_misc;
    run(8'h79, 1, 64'hffff000104000005);
    run(8'h7a, 1, 64'hffff000100400005);
    run(8'h7b, 1, 64'h81800130fe038006);
    $display("test misc done");
  endtask
  task t_refuse;
    run(8'h70, 0, 64'h81800130fe038006);
    run(8'h7c, 0, 64'h81800130fe038006);
    run_word({6'h0b, 5'h11, 13'h0, 8'h71}, 0, 64'h81800130fe038006);
    run_word({6'h0a, 5'h05, 5'h01, 5'h02, 3'h7, 8'h7b}, 1, 64'h81800130fe038006);
    $display("test refuse done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    t_reset;
    rst_n = 1'b1;
    t_wrap;
    t_sat;
    t_misc;
    t_refuse;
    wrap_up;
  end
  // about 42 cycles of traffic; twelve times that is a hang
  initial begin
    #5000;
    fail_count++;
    wrap_up;
  end
endmodule // vsx_alu_tb_top
